// file: dcrs_pkg.sv
/*
  Shared constants for the six-channel request-source decode and channel control/status block.
  Assumes a 32-bit Avalon-MM byte address and one aligned 32-bit word per register.
*/
package dcrs_pkg;
  localparam int NUM_CH = 6;
  localparam int NUM_PREQ = 14;
  localparam logic [31:0] CSR_OFS [NUM_CH] = '{32'h1302_0010, 32'h1302_0030, 32'h1302_0050,
                                               32'h1302_0070, 32'h1302_0090, 32'h1302_00B0};
  localparam logic [31:0] SEL_BASE = 32'h1302_0400;
  localparam logic [31:0] SEL_STRIDE = 32'h0000_0004;
  localparam logic [31:0] CSR_RESET = 32'h0000_0000;
  localparam logic [5:0] SEL_RESET = 6'h00;
  localparam int BIT_DESCRIPTORLESS_SELECT = 31;
  localparam int BIT_LONG_DESCRIPTOR_SELECT = 30;
  localparam int LAST_DONE_DESC_OFFSET_LSB = 16;
  localparam int LAST_DONE_DESC_OFFSET_MSB = 23;
  localparam int BIT_ECC = 7;
  localparam int BIT_INV = 6;
  localparam int BIT_AR = 4;
  localparam int BIT_TT = 3;
  localparam int BIT_HLT = 2;
  localparam int BIT_CT = 1;
  localparam int BIT_CTE = 0;
  localparam int FLG_CT = 0;
  localparam int FLG_HLT = 1;
  localparam int FLG_TT = 2;
  localparam int FLG_AR = 3;
  localparam int FLG_INV = 4;
  localparam int FLG_ECC = 5;
  localparam logic [5:0] SRC_SSI0_TX = 6'h16;
  localparam logic [5:0] SRC_SSI0_RX = 6'h17;
  localparam logic [5:0] SRC_AUD_TX = 6'h18;
  localparam logic [5:0] SRC_AUD_RX = 6'h19;
  localparam logic [5:0] SRC_CARD0_TX = 6'h1A;
  localparam logic [5:0] SRC_CARD0_RX = 6'h1B;
  localparam logic [5:0] SRC_TIMER = 6'h1C;
  localparam logic [5:0] SRC_CONV = 6'h1D;
  localparam logic [5:0] SRC_CARD1_TX = 6'h1E;
  localparam logic [5:0] SRC_CARD1_RX = 6'h1F;
  localparam logic [5:0] SRC_SYNC_SERIAL_IF_1_TX = 6'h20;
  localparam logic [5:0] SRC_SYNC_SERIAL_IF_1_RX = 6'h21;
  localparam logic [5:0] SRC_REM_TX = 6'h22;
  localparam logic [5:0] SRC_REM_RX = 6'h23;
  typedef enum logic [1:0] {
    DIR_NONE = 2'b00,
    DIR_TO_PERIPH = 2'b01,
    DIR_FROM_PERIPH = 2'b10,
    DIR_MEM_TO_MEM = 2'b11
  } dcrs_dir_t;
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } dcrs_bus_state_t;
endpackage : dcrs_pkg

// file: dcrs_req_decode.sv
/*
  Request-source decode for one channel: picks the pacing request and transfer direction.
  Assumes peripheral requests come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module dcrs_req_decode
  import dcrs_pkg::*;
(
  input wire logic [5:0] src_code,
  input wire logic [dcrs_pkg::NUM_PREQ-1:0] periph_req,
  output logic req,
  output dcrs_pkg::dcrs_dir_t dir
);
  always_comb begin
    req = 1'b0;
    dir = DIR_NONE;
    case (src_code)
      SRC_SSI0_TX: begin req = periph_req[0]; dir = DIR_TO_PERIPH; end
      SRC_SSI0_RX: begin req = periph_req[1]; dir = DIR_FROM_PERIPH; end
      SRC_AUD_TX: begin req = periph_req[2]; dir = DIR_TO_PERIPH; end
      SRC_AUD_RX: begin req = periph_req[3]; dir = DIR_FROM_PERIPH; end
      SRC_CARD0_TX: begin req = periph_req[4]; dir = DIR_TO_PERIPH; end
      SRC_CARD0_RX: begin req = periph_req[5]; dir = DIR_FROM_PERIPH; end
      SRC_TIMER: begin req = periph_req[6]; dir = DIR_MEM_TO_MEM; end
      SRC_CONV: begin req = periph_req[7]; dir = DIR_FROM_PERIPH; end
      SRC_CARD1_TX: begin req = periph_req[8]; dir = DIR_TO_PERIPH; end
      SRC_CARD1_RX: begin req = periph_req[9]; dir = DIR_FROM_PERIPH; end
      SRC_SYNC_SERIAL_IF_1_TX: begin req = periph_req[10]; dir = DIR_TO_PERIPH; end
      SRC_SYNC_SERIAL_IF_1_RX: begin req = periph_req[11]; dir = DIR_FROM_PERIPH; end
      SRC_REM_TX: begin req = periph_req[12]; dir = DIR_TO_PERIPH; end
      SRC_REM_RX: begin req = periph_req[13]; dir = DIR_FROM_PERIPH; end
      default: begin
        req = 1'b0;
        dir = DIR_NONE;
      end
    endcase
  end
endmodule : dcrs_req_decode
`default_nettype wire

// file: dcrs_chan_flags.sv
/*
  Status flags of one channel: hardware sets, software writes, and a set beats a write.
  Assumes a synchronous active-low reset copy and a clock enable from the top.
*/
`timescale 1ns/10ps
`default_nettype none
module dcrs_chan_flags (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [5:0] wr_flags,
  input wire logic [5:0] set_flags,
  output logic [5:0] flags
);
  genvar b;
  generate
    for (b = 0; b < 6; b++) begin : g_flag
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          flags[b] <= 1'b0;
        end else if (ce) begin
          if (set_flags[b]) begin
            flags[b] <= 1'b1;
          end else if (wr_en) begin
            flags[b] <= wr_flags[b];
          end
        end
      end
    end
  endgenerate
endmodule : dcrs_chan_flags
`default_nettype wire

// file: dcrs_dma_chan_regs.sv
/*
  Six-channel DMA request-source selection and channel control/status registers on Avalon-MM.
  Assumes the transfer engine and the peripherals run on mclk and report events as one-cycle pulses.
*/
// Behaviour
// - First serial port codes 010110 and 010111 decoded.
// - Audio codes 011000 and 011001 decoded.
// - First card host codes 011010, 011011 decoded.
// - Code 011100 selects timer, memory to memory.
// - Code 011101 selects converter into memory.
// - Second card host codes 011110, 011111 decoded.
// - Second serial port codes 100000, 100001 decoded.
// - Remaining unit 100010, 100011; others reserved.
// - Bit 31 picks descriptorless operation.
// - Bit 30 picks eight-word descriptors.
// - Bits 23:16 copy completed descriptor offset.
// - Bit 7 flags ECC error, channel 0.
// - Bit 6 flags invalid loaded descriptor.
// - Bit 4 flags address error.
// - Bit 3 flags unlinked or descriptorless end.
// - Bit 2 reads one when channel halted.
// - Bit 1 flags linked chain end.
// - Reserved bits ignore writes, read zero.
`timescale 1ns/10ps
`default_nettype none
module dcrs_dma_chan_regs
  import dcrs_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [dcrs_pkg::NUM_PREQ-1:0] periph_req,
  input wire logic [dcrs_pkg::NUM_CH-1:0] desc_done,
  input wire logic [8*dcrs_pkg::NUM_CH-1:0] desc_offset,
  input wire logic [dcrs_pkg::NUM_CH-1:0] desc_loaded,
  input wire logic [dcrs_pkg::NUM_CH-1:0] desc_loaded_valid,
  input wire logic [dcrs_pkg::NUM_CH-1:0] addr_fault,
  input wire logic ecc_fault,
  input wire logic [dcrs_pkg::NUM_CH-1:0] xfer_end,
  input wire logic [dcrs_pkg::NUM_CH-1:0] chain_end,
  output logic [dcrs_pkg::NUM_CH-1:0] chan_req,
  output logic [2*dcrs_pkg::NUM_CH-1:0] chan_dir,
  output logic [dcrs_pkg::NUM_CH-1:0] descriptorless_select,
  output logic [dcrs_pkg::NUM_CH-1:0] long_descriptor_select,
  output logic [dcrs_pkg::NUM_CH-1:0] channel_enable_bit
);
  import dcrs_pkg::*;

  logic rst_meta_n;
  logic rst_n;
  dcrs_bus_state_t bus_state;
  dcrs_bus_state_t next_bus_state;
  logic [31:0] wmask;
  logic wr_commit;
  logic [NUM_CH-1:0] hit_csr;
  logic [NUM_CH-1:0] hit_sel;
  logic [NUM_CH-1:0] wr_csr;
  logic [NUM_CH-1:0] wr_sel;
  logic [31:0] csr_word [NUM_CH];
  logic [31:0] new_csr [NUM_CH];
  logic [5:0] req_sel [NUM_CH];
  logic [7:0] last_done_desc_offset [NUM_CH];
  logic [5:0] flags [NUM_CH];
  logic [5:0] set_flags [NUM_CH];
  logic [NUM_CH-1:0] dec_req;
  dcrs_dir_t dec_dir [NUM_CH];
  logic [31:0] next_readdata;

  // The reset is released through two flip-flops; everything else uses the copy.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // Each request waits one cycle; the answer comes on the second edge.
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_bus_state = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= BUS_IDLE;
    end else if (ce) begin
      bus_state <= next_bus_state;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && (bus_state != BUS_ANSWER || !ce);
  assign wr_commit = avs_write && bus_state == BUS_ANSWER && ce;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
                  {8{avs_byteenable[0]}}};

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      assign hit_csr[i] = avs_address == CSR_OFS[i];
      assign hit_sel[i] = avs_address == SEL_BASE + SEL_STRIDE * 32'(i);
      assign wr_csr[i] = wr_commit && hit_csr[i];
      assign wr_sel[i] = wr_commit && hit_sel[i];

      // Reserved fields are built as constant zeros, so they never store and always read zero.
      assign csr_word[i] = {descriptorless_select[i], long_descriptor_select[i], 6'h00,
                            last_done_desc_offset[i], 8'h00,
                            flags[i][FLG_ECC], flags[i][FLG_INV], 1'b0,
                            flags[i][FLG_AR], flags[i][FLG_TT], flags[i][FLG_HLT],
                            flags[i][FLG_CT], channel_enable_bit[i]};
      assign new_csr[i] = (csr_word[i] & ~wmask) | (avs_writedata & wmask);

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          descriptorless_select[i] <= CSR_RESET[BIT_DESCRIPTORLESS_SELECT];
          long_descriptor_select[i] <= CSR_RESET[BIT_LONG_DESCRIPTOR_SELECT];
          channel_enable_bit[i] <= CSR_RESET[BIT_CTE];
        end else if (ce && wr_csr[i]) begin
          descriptorless_select[i] <= new_csr[i][BIT_DESCRIPTORLESS_SELECT];
          long_descriptor_select[i] <= new_csr[i][BIT_LONG_DESCRIPTOR_SELECT];
          channel_enable_bit[i] <= new_csr[i][BIT_CTE];
        end
      end

      // A completed descriptor's offset wins over a software write in the same cycle.
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          last_done_desc_offset[i] <= CSR_RESET[LAST_DONE_DESC_OFFSET_MSB:LAST_DONE_DESC_OFFSET_LSB];
        end else if (ce) begin
          if (desc_done[i] && !descriptorless_select[i]) begin
            last_done_desc_offset[i] <= desc_offset[8*i +: 8];
          end else if (wr_csr[i]) begin
            last_done_desc_offset[i] <= new_csr[i][LAST_DONE_DESC_OFFSET_MSB:LAST_DONE_DESC_OFFSET_LSB];
          end
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          req_sel[i] <= SEL_RESET;
        end else if (ce && wr_sel[i]) begin
          req_sel[i] <= (req_sel[i] & ~wmask[5:0]) | (avs_writedata[5:0] & wmask[5:0]);
        end
      end

      // Hardware events that set status flags; descriptor-only events are dropped without descriptors.
      always_comb begin
        set_flags[i] = 6'h00;
        set_flags[i][FLG_CT] = chain_end[i] && !descriptorless_select[i];
        set_flags[i][FLG_TT] = xfer_end[i];
        set_flags[i][FLG_AR] = addr_fault[i];
        set_flags[i][FLG_INV] = desc_loaded[i] && !desc_loaded_valid[i] && !descriptorless_select[i];
        set_flags[i][FLG_ECC] = (i == 0) && ecc_fault;
        set_flags[i][FLG_HLT] = addr_fault[i] || set_flags[i][FLG_INV] || set_flags[i][FLG_ECC]
                                || xfer_end[i] || set_flags[i][FLG_CT];
      end

      dcrs_chan_flags u_flags (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .wr_en(wr_csr[i]),
        .wr_flags({new_csr[i][BIT_ECC] && (i == 0), new_csr[i][BIT_INV], new_csr[i][BIT_AR],
                   new_csr[i][BIT_TT], new_csr[i][BIT_HLT], new_csr[i][BIT_CT]}),
        .set_flags(set_flags[i]),
        .flags(flags[i])
      );

      dcrs_req_decode u_decode (
        .src_code(req_sel[i]),
        .periph_req(periph_req),
        .req(dec_req[i]),
        .dir(dec_dir[i])
      );

      // Requests pass only while the channel is enabled and not halted.
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          chan_req[i] <= 1'b0;
          chan_dir[2*i +: 2] <= DIR_NONE;
        end else if (ce) begin
          chan_req[i] <= channel_enable_bit[i] && !flags[i][FLG_HLT] && dec_req[i];
          chan_dir[2*i +: 2] <= dec_dir[i];
        end
      end
    end
  endgenerate

  // Unmapped addresses read as zero and ignore writes.
  always_comb begin
    next_readdata = 32'h0000_0000;
    for (int k = 0; k < NUM_CH; k++) begin
      if (hit_csr[k]) begin
        next_readdata = csr_word[k];
      end
      if (hit_sel[k]) begin
        next_readdata = {26'h000_0000, req_sel[k]};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && bus_state == BUS_IDLE && avs_read) begin
      avs_readdata <= next_readdata;
    end
  end
endmodule : dcrs_dma_chan_regs
`default_nettype wire

// file: dcrs_asserts.sv
/*
  Checker for the channel register block, bound to its top module.
  Assumes ce is held high and the bus master waits on waitrequest.
*/
`timescale 1ns/10ps
`default_nettype none
module dcrs_asserts (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [5:0] addr_fault,
  input wire logic [5:0] xfer_end,
  input wire logic [5:0] chan_req,
  input wire logic [5:0] descriptorless_select,
  input wire logic [5:0] long_descriptor_select,
  input wire logic [5:0] channel_enable_bit
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  logic csr_rd;
  logic wr0;
  logic [5:0] stop;
  assign csr_rd = avs_read && !avs_waitrequest && avs_address[31:8] == 24'h130200 && avs_address[4:0] == 5'h10;
  assign wr0 = avs_write && !avs_waitrequest && avs_address == 32'h1302_0010;
  assign stop = xfer_end | addr_fault;
  sequence s_take; $rose(avs_read || avs_write); endsequence
  sequence s_answer; avs_waitrequest ##1 !avs_waitrequest; endsequence
  property p_one_wait; s_take |-> s_answer; endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("Bus answer not after one wait cycle.");
  property p_rd_hold; avs_read && !avs_waitrequest |=> $stable(avs_readdata); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("Read data did not hold.");
  property p_resv; csr_rd |-> (avs_readdata & 32'h3F00_FF20) == 32'h0; endproperty
  a_resv: assert property (p_resv)
    else $error("Reserved bits read nonzero.");
  property p_ecc; csr_rd && avs_address[7:5] != 3'h0 |-> !avs_readdata[7]; endproperty
  a_ecc: assert property (p_ecc)
    else $error("ECC flag seen on a channel other than 0.");
  property p_descriptorless_select; wr0 && avs_byteenable[3] |=> descriptorless_select[0] == $past(avs_writedata[31]); endproperty
  a_descriptorless_select: assert property (p_descriptorless_select)
    else $error("Transfer style bit not taken from write.");
  property p_long_descriptor_select; wr0 && avs_byteenable[3] |=> long_descriptor_select[0] == $past(avs_writedata[30]); endproperty
  a_long_descriptor_select: assert property (p_long_descriptor_select)
    else $error("Descriptor length bit not taken from write.");
  property p_cte; wr0 && avs_byteenable[0] |=> channel_enable_bit[0] == $past(avs_writedata[0]); endproperty
  a_cte: assert property (p_cte)
    else $error("Enable bit not taken from write.");
  property p_req_en; chan_req != 6'h0 |-> (chan_req & ~$past(channel_enable_bit)) == 6'h0; endproperty
  a_req_en: assert property (p_req_en)
    else $error("Request on a disabled channel.");
  property p_halt; stop != 6'h0 |-> ##2 (chan_req & $past(stop, 2)) == 6'h0; endproperty
  a_halt: assert property (p_halt)
    else $error("Request after the channel halted.");
endmodule : dcrs_asserts
bind dcrs_dma_chan_regs dcrs_asserts u_chk (.mclk, .arst_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .addr_fault, .xfer_end, .chan_req,
  .descriptorless_select, .long_descriptor_select, .channel_enable_bit);
`default_nettype wire

// file: dcrs_periph_model.sv
/*
  Model of the peripheral FIFOs raising fourteen level requests.
  Assumes the bench sets want and lag after a rising edge; lag slows the answer.
*/
`timescale 1ns/10ps
`default_nettype none
module dcrs_periph_model (
  input wire logic mclk,
  input wire logic [13:0] want,
  input wire logic [1:0] lag,
  output logic [13:0] periph_req
);
  logic [1:0] cnt = 2'h0;
  always @(posedge mclk) begin
    if (cnt == 2'h0) begin
      periph_req <= want;
      cnt <= lag;
    end else begin
      cnt <= cnt - 2'h1;
    end
  end
endmodule : dcrs_periph_model
`default_nettype wire

// file: tb_top.sv
/*
  Self-checking bench for the channel register block with a register model.
  Assumes the checker is bound to the design and ce is held high.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, x, g) begin cmp_count++; if ((g) !== (x)) begin num_errors++; \
  $display("Error %s expected %h seen %h", n, x, g); end end
module tb_top;
  import dcrs_pkg::*;
  logic mclk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, ecc_fault = 1'b0, avs_waitrequest, ok;
  logic [31:0] avs_address = 32'h0, avs_writedata = 32'h0, avs_readdata, setv, q;
  logic [3:0] avs_byteenable = 4'h0;
  logic [13:0] want = 14'h0, periph_req, w;
  logic [1:0] lag = 2'h0;
  logic [5:0] desc_done = 6'h0, desc_loaded = 6'h0, desc_loaded_valid = 6'h0, addr_fault = 6'h0;
  logic [5:0] xfer_end = 6'h0, chain_end = 6'h0, chan_req, descriptorless_select, long_descriptor_select;
  logic [5:0] channel_enable_bit, ev, ch;
  logic skip;
  logic [11:0] chan_dir;
  logic [47:0] desc_offset = 48'h0;
  logic [7:0] ofs;
  logic [31:0] csr [6];
  logic [31:0] tbl [6] = '{32'hC, 32'h6, 32'h14, 32'h44, 32'h0, 32'h84};
  int k, c, m, e, num_errors = 0, cmp_count = 0;
  integer seed = 32'h2977E104;
  always #5 mclk = ~mclk;
  dcrs_periph_model peri (.mclk, .want, .lag, .periph_req);
  dcrs_dma_chan_regs dut (.mclk, .arst_n, .ce(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .periph_req, .desc_done, .desc_offset, .desc_loaded,
    .desc_loaded_valid, .addr_fault, .ecc_fault, .xfer_end, .chain_end, .chan_req, .chan_dir,
    .descriptorless_select, .long_descriptor_select, .channel_enable_bit);
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d.", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] r);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      close_out();
    end
    @(posedge mclk);
  endtask : bus
  task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic [31:0] mk);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, 4'hF, r);
    `CHK("readdata", x & mk, r & mk)
  endtask : rd
  task automatic csr_wr(input int n, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] mk;
    logic [31:0] r;
    mk = (n == 0 ? 32'hC0FF_00DF : 32'hC0FF_005F) & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    bus(1'b1, CSR_OFS[n], d, be, r);
    csr[n] = (csr[n] & ~mk) | (d & mk);
  endtask : csr_wr
  function automatic logic [1:0] edir(input int code);
    if (code < 32'h16 || code > 32'h23)
      return 2'b00;
    return code == 32'h1C ? 2'b11 : (code % 2 == 1 ? 2'b10 : 2'b01);
  endfunction : edir
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (k = 0; k < 6; k++) begin
      csr[k] = CSR_RESET;
      rd(CSR_OFS[k], CSR_RESET, '1);
      rd(SEL_BASE + SEL_STRIDE * k, 32'h0, '1);
    end
    for (c = 0; c < 24; c++) begin
      k = $unsigned($random(seed)) % 6;
      csr_wr(k, $random(seed), 4'($random(seed)));
      rd(CSR_OFS[k], csr[k], '1);
      `CHK("descriptorless_select", csr[k][BIT_DESCRIPTORLESS_SELECT], descriptorless_select[k])
      `CHK("long_descriptor_select", csr[k][BIT_LONG_DESCRIPTOR_SELECT], long_descriptor_select[k])
      `CHK("channel_enable_bit", csr[k][BIT_CTE], channel_enable_bit[k])
    end
    bus(1'b1, 32'h1302_0014, '1, 4'hF, q);
    rd(32'h1302_0014, 32'h0, '1);
    rd(CSR_OFS[0], csr[0], '1);
    for (c = 32'h15; c <= 32'h24; c++) begin
      k = c % 6;
      ok = c >= 32'h16 && c <= 32'h23;
      w = ok ? 14'h1 << (c - 32'h16) : 14'h3FFF;
      bus(1'b1, SEL_BASE + SEL_STRIDE * k, c, 4'hF, q);
      csr_wr(k, 32'h1, 4'hF);
      want <= w;
      lag <= 2'($random(seed));
      repeat (6) @(posedge mclk);
      `CHK("chan_req", ok, chan_req[k])
      `CHK("chan_dir", edir(c), chan_dir[2*k +: 2])
      want <= ~w;
      repeat (6) @(posedge mclk);
      `CHK("chan_req", 1'b0, chan_req[k])
      want <= w;
      csr_wr(k, 32'h0, 4'h1);
      repeat (6) @(posedge mclk);
      `CHK("chan_req", 1'b0, chan_req[k])
    end
    for (m = 0; m < 3; m++) begin
      for (e = 0; e < 6; e++) begin
        k = (e == 5) ? 0 : $unsigned($random(seed)) % 6;
        ch = 6'h1 << k;
        ev = 6'h1 << e;
        ofs = 8'($random(seed));
        skip = (m == 1 && (e == 1 || e == 3 || e == 4)) || (m == 2 && e == 3);
        bus(1'b1, SEL_BASE + SEL_STRIDE * k, SRC_SSI0_TX + 6'(k), 4'hF, q);
        want <= 14'h1 << k;
        desc_loaded_valid <= (m == 2) ? 6'h3F : 6'h00;
        csr_wr(k, {m[0], 31'h1}, 4'hF);
        repeat (4) @(posedge mclk);
        `CHK("chan_req", 1'b1, chan_req[k])
        xfer_end <= ev[0] ? ch : 6'h0;
        chain_end <= ev[1] ? ch : 6'h0;
        addr_fault <= ev[2] ? ch : 6'h0;
        desc_loaded <= ev[3] ? ch : 6'h0;
        desc_done <= ev[4] ? ch : 6'h0;
        ecc_fault <= ev[5];
        desc_offset <= {6{ofs}};
        @(posedge mclk);
        {xfer_end, chain_end, addr_fault, desc_loaded, desc_done, ecc_fault} <= 31'h0;
        repeat (2) @(posedge mclk);
        `CHK("chan_req", e == 4 || skip, chan_req[k])
        setv = skip ? 32'h0 : (e == 4 ? {8'h0, ofs, 16'h0} : tbl[e]);
        rd(CSR_OFS[k], csr[k] | setv, '1);
      end
    end
    want <= 14'h0;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
